//--- verilog/emcs_sequencer.v
// eeprom margin command sequencer with avalon-mm register slave
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "emcs_defines.vh"

// Summary of operation
// - field margin command 0x0E accepted only in special mode, else access error
// - word 0 selects block, word 1 gives margin; applied, then completion flag
// - eeprom margin hits eeprom reads; pflash margin hits both
// - margin encodings 0x0000 through 0x0004 are valid
// - margin: access error on index not 001, bad block or bad level
// - any command not allowed in mode or security raises access error
// - section verify checks blank words; failure sets both verify flags
// - section verify access error: index, address, odd, past block end
// - program command 0x11 writes one to four words per launch index
// - program access error: index range, address, odd, past block end
// - program and erase on protected area raise protection flag, no change
// - after program or erase, verify and report errors, then complete
// - sector erase 0x12 erases the whole addressed sector then verifies
// - sector erase access error: index not 001, bad address, odd
// - clearing completion flag launches command with loaded words
module emcs_sequencer
(
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  output reg         irq_o,
  output reg  [2:0]  pflash_margin_o,
  output reg  [2:0]  eeprom_margin_o,
  output reg         arr_req_o,
  output reg  [1:0]  arr_op_o,
  output reg  [15:0] arr_addr_o,
  output reg  [15:0] arr_data_o,
  input  wire        arr_ack_i,
  input  wire        arr_blank_fail_i,
  input  wire        arr_err_i,
  input  wire        arr_unc_i
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_CHECK = 2'h1;
  localparam ST_RUN   = 2'h2;
  localparam ST_DONE  = 2'h3;

  localparam OP_READ  = 2'h0;
  localparam OP_PROG  = 2'h1;
  localparam OP_ERASE = 2'h2;

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  reg  [1:0]  state_q;
  reg         ccf_q;
  reg         acc_q;
  reg         prot_q;
  reg         ver_q;
  reg         unc_q;
  reg  [2:0]  index_q;
  reg  [15:0] param_q [0:5];
  reg  [1:0]  cfg_q;
  reg  [1:0]  irq_stat_q;
  reg  [1:0]  irq_mask_q;
  reg  [15:0] prot_lo_q;
  reg  [15:0] ex_word_q [0:5];
  reg  [2:0]  ex_ix_q;
  reg  [15:0] cur_addr_q;
  reg  [15:0] left_q;
  reg  [2:0]  wsel_q;
  reg         ack_s1_q;
  reg         ack_s2_q;
  reg         blank_s1_q;
  reg         blank_s2_q;
  reg         err_s1_q;
  reg         err_s2_q;
  reg         unc_s1_q;
  reg         unc_s2_q;
  reg         ack_d2_q;
  integer     i;

  wire        ack_rise = ack_s2_q & ~ack_d2_q;
  wire [7:0]  cmd      = ex_word_q[0][15:8];
  wire [1:0]  hi_addr  = ex_word_q[0][1:0];
  wire [15:0] lo_addr  = ex_word_q[1];
  wire [15:0] margin   = ex_word_q[1];
  wire [1:0]  blk_sel  = ex_word_q[0][1:0];
  wire        special  = cfg_q[`EMCS_CFG_SPECIAL];
  wire        secure   = cfg_q[`EMCS_CFG_SECURE];
  wire        addr_ok  = (hi_addr == `EMCS_EE_HI) && (lo_addr >= `EMCS_EE_BASE) &&
                         (lo_addr <= `EMCS_EE_END);
  wire        odd      = lo_addr[0];

  // section length in words for verify and program
  wire [15:0] nwords   = (cmd == `EMCS_CMD_EVSECT) ? ex_word_q[2] :
                         {13'h0000, ex_ix_q} - 16'h0001;
  wire [16:0] sect_end = {1'b0, lo_addr} + {nwords[14:0], 1'b0} - 17'h00001;
  wire        fits     = (nwords != 16'h0000) && (sect_end <= {1'b0, `EMCS_EE_END});
  wire [15:0] sect_adr = lo_addr & `EMCS_SECT_MASK;
  // last byte touched must sit below the protect bound, not only the first
  wire [16:0] sect_top = {1'b0, sect_adr} + 17'h00003;
  wire        in_prot  = (cmd == `EMCS_CMD_ERASE) ?
                         (sect_top >= {1'b0, prot_lo_q}) :
                         (sect_end >= {1'b0, prot_lo_q});

  // ---------------------------------------------------------------------------
  // launch checks
  // ---------------------------------------------------------------------------
  // judged on the captured copy, one cycle after launch
  reg         chk_acc;
  reg         chk_prot;
  always @*
  begin
    chk_acc  = 1'b0;
    chk_prot = 1'b0;
    case (cmd)
      `EMCS_CMD_FMARGIN:
      begin
        chk_acc = ~special | secure;
        if (ex_ix_q != `EMCS_IX_001)
          chk_acc = 1'b1;
        if (blk_sel != `EMCS_BLK_PFLASH && blk_sel != `EMCS_BLK_EEPROM)
          chk_acc = 1'b1;
        if (margin > `EMCS_MRG_MAX)
          chk_acc = 1'b1;
      end
      `EMCS_CMD_EVSECT:
      begin
        chk_acc = secure & ~special;
        if (ex_ix_q != `EMCS_IX_010 || !addr_ok || odd || !fits)
          chk_acc = 1'b1;
      end
      `EMCS_CMD_PROG:
      begin
        chk_acc = secure & ~special;
        if (ex_ix_q < `EMCS_IX_010 || ex_ix_q > `EMCS_IX_101)
          chk_acc = 1'b1;
        if (!addr_ok || odd || !fits)
          chk_acc = 1'b1;
        chk_prot = in_prot;
      end
      `EMCS_CMD_ERASE:
      begin
        chk_acc = secure & ~special;
        if (ex_ix_q != `EMCS_IX_001 || !addr_ok || odd)
          chk_acc = 1'b1;
        chk_prot = in_prot;
      end
      default:
        chk_acc = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------------------
  // bus slave and sequencer
  // ---------------------------------------------------------------------------
  wire        wr       = avs_write_i & avs_waitrequest_o;
  wire        rd       = avs_read_i & avs_waitrequest_o;
  wire        launch   = wr && (avs_address_i == `EMCS_OFS_STATUS) &&
                         avs_writedata_i[`EMCS_ST_CCF] && ccf_q;
  wire        set_done = (state_q == ST_DONE);
  wire        idle     = ccf_q;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q           <= ST_IDLE;
      ccf_q             <= 1'b1;
      acc_q             <= 1'b0;
      prot_q            <= 1'b0;
      ver_q             <= 1'b0;
      unc_q             <= 1'b0;
      index_q           <= 3'h0;
      cfg_q             <= 2'h0;
      irq_stat_q        <= 2'h0;
      irq_mask_q        <= 2'h0;
      prot_lo_q         <= 16'hFFFF;
      ex_ix_q           <= 3'h0;
      cur_addr_q        <= 16'h0000;
      left_q            <= 16'h0000;
      wsel_q            <= 3'h0;
      avs_readdata_o    <= 32'h00000000;
      avs_waitrequest_o <= 1'b1;
      irq_o             <= 1'b0;
      pflash_margin_o   <= 3'h0;
      eeprom_margin_o   <= 3'h0;
      arr_req_o         <= 1'b0;
      arr_op_o          <= OP_READ;
      arr_addr_o        <= 16'h0000;
      arr_data_o        <= 16'h0000;
      ack_s1_q          <= 1'b0;
      ack_s2_q          <= 1'b0;
      blank_s1_q        <= 1'b0;
      blank_s2_q        <= 1'b0;
      err_s1_q          <= 1'b0;
      err_s2_q          <= 1'b0;
      unc_s1_q          <= 1'b0;
      unc_s2_q          <= 1'b0;
      ack_d2_q          <= 1'b0;
      for (i = 0; i < 6; i = i + 1)
      begin
        param_q[i]   <= 16'h0000;
        ex_word_q[i] <= 16'h0000;
      end
    end
    else
    begin
      // -----------------------------------------------------------------------
      // array result synchronisers
      // -----------------------------------------------------------------------
      ack_s1_q   <= arr_ack_i;
      ack_s2_q   <= ack_s1_q;
      ack_d2_q   <= ack_s2_q;
      blank_s1_q <= arr_blank_fail_i;
      blank_s2_q <= blank_s1_q;
      err_s1_q   <= arr_err_i;
      err_s2_q   <= err_s1_q;
      unc_s1_q   <= arr_unc_i;
      unc_s2_q   <= unc_s1_q;
      // one wait cycle per access, answer on the second edge
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      irq_o <= |(irq_stat_q & irq_mask_q);
      if (rd)
      begin
        case (avs_address_i)
          `EMCS_OFS_STATUS:
            avs_readdata_o <= {24'h000000, ccf_q, 1'b0, acc_q, prot_q, 2'h0, ver_q, unc_q};
          `EMCS_OFS_INDEX:    avs_readdata_o <= {29'h00000000, index_q};
          `EMCS_OFS_PARAM:
            avs_readdata_o <= (index_q <= `EMCS_IX_101) ?
                              {16'h0000, param_q[index_q]} : 32'h00000000;
          `EMCS_OFS_CONFIG:   avs_readdata_o <= {30'h00000000, cfg_q};
          `EMCS_OFS_IRQ_STAT: avs_readdata_o <= {30'h00000000, irq_stat_q};
          `EMCS_OFS_IRQ_MASK: avs_readdata_o <= {30'h00000000, irq_mask_q};
          `EMCS_OFS_MARGIN:
            avs_readdata_o <= {24'h000000, 1'b0, pflash_margin_o, 1'b0, eeprom_margin_o};
          `EMCS_OFS_PROT:     avs_readdata_o <= {16'h0000, prot_lo_q};
          default:            avs_readdata_o <= 32'h00000000;
        endcase
      end
      // parameter words and config are only writable while idle
      if (wr && idle)
      begin
        case (avs_address_i)
          `EMCS_OFS_INDEX:  index_q <= avs_writedata_i[2:0];
          `EMCS_OFS_PARAM:
            if (index_q <= `EMCS_IX_101)
              param_q[index_q] <= avs_writedata_i[15:0];
          `EMCS_OFS_CONFIG: cfg_q <= avs_writedata_i[1:0];
          `EMCS_OFS_PROT:   prot_lo_q <= avs_writedata_i[15:0];
          `EMCS_OFS_STATUS:
          begin
            if (avs_writedata_i[`EMCS_ST_ACC])
              acc_q <= 1'b0;
            if (avs_writedata_i[`EMCS_ST_PROT])
              prot_q <= 1'b0;
          end
          default: ;
        endcase
      end
      // -----------------------------------------------------------------------
      // interrupt status and mask
      // -----------------------------------------------------------------------
      if (wr && avs_address_i == `EMCS_OFS_IRQ_MASK)
        irq_mask_q <= avs_writedata_i[1:0];
      // set wins over the write-one clear
      irq_stat_q[`EMCS_IRQ_DONE] <= set_done |
        (irq_stat_q[`EMCS_IRQ_DONE] &
         ~(wr && avs_address_i == `EMCS_OFS_IRQ_STAT && avs_writedata_i[`EMCS_IRQ_DONE]));
      irq_stat_q[`EMCS_IRQ_ERR] <= (set_done & (acc_q | prot_q | ver_q)) |
        (irq_stat_q[`EMCS_IRQ_ERR] &
         ~(wr && avs_address_i == `EMCS_OFS_IRQ_STAT && avs_writedata_i[`EMCS_IRQ_ERR]));
      // -----------------------------------------------------------------------
      // command state machine
      // -----------------------------------------------------------------------
      case (state_q)
        ST_IDLE:
          if (launch && !acc_q && !prot_q)
          begin
            ccf_q   <= 1'b0;
            ver_q   <= 1'b0;
            unc_q   <= 1'b0;
            ex_ix_q <= index_q;
            for (i = 0; i < 6; i = i + 1)
              ex_word_q[i] <= param_q[i];
            state_q <= ST_CHECK;
          end
        ST_CHECK:
        begin
          if (chk_acc || chk_prot)
          begin
            acc_q   <= chk_acc;
            prot_q  <= chk_prot & ~chk_acc;
            state_q <= ST_DONE;
          end
          else if (cmd == `EMCS_CMD_FMARGIN)
          begin
            if (blk_sel == `EMCS_BLK_PFLASH)
            begin
              pflash_margin_o <= margin[2:0];
              eeprom_margin_o <= margin[2:0];
            end
            else
              eeprom_margin_o <= margin[2:0];
            state_q <= ST_DONE;
          end
          else
          begin
            wsel_q    <= 3'h2;
            arr_req_o <= 1'b1;
            if (cmd == `EMCS_CMD_ERASE)
            begin
              arr_op_o   <= OP_ERASE;
              cur_addr_q <= sect_adr;
              arr_addr_o <= sect_adr;
              left_q     <= 16'h0001;
            end
            else
            begin
              arr_op_o   <= (cmd == `EMCS_CMD_PROG) ? OP_PROG : OP_READ;
              cur_addr_q <= lo_addr;
              arr_addr_o <= lo_addr;
              left_q     <= nwords;
            end
            arr_data_o <= ex_word_q[2];
            state_q    <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          // four-phase: hold request until synced ack, next word once ack is gone
          if (arr_req_o && ack_s2_q)
            arr_req_o <= 1'b0;
          if (ack_rise)
          begin
            // the array performs its own verify after program or erase
            if (blank_s2_q || err_s2_q)
              ver_q <= 1'b1;
            if (blank_s2_q || unc_s2_q)
              unc_q <= 1'b1;
          end
          if (!arr_req_o && !ack_s2_q)
          begin
            if (left_q <= 16'h0001)
              state_q <= ST_DONE;
            else
            begin
              left_q     <= left_q - 16'h0001;
              cur_addr_q <= cur_addr_q + 16'h0002;
              arr_addr_o <= cur_addr_q + 16'h0002;
              // long verify sections run past the last stored word
              arr_data_o <= (wsel_q < 3'h5) ? ex_word_q[wsel_q + 3'h1] : 16'h0000;
              wsel_q     <= wsel_q + 3'h1;
              arr_req_o  <= 1'b1;
            end
          end
        end
        ST_DONE:
        begin
          ccf_q   <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // emcs_sequencer
`default_nettype wire

//--- verilog/emcs_defines.vh
// register map, field positions and command codes for the margin command sequencer
`ifndef EMCS_DEFINES_VH
`define EMCS_DEFINES_VH
// register word offsets
`define EMCS_OFS_STATUS     4'h0
`define EMCS_OFS_INDEX      4'h1
`define EMCS_OFS_PARAM      4'h2
`define EMCS_OFS_CONFIG     4'h3
`define EMCS_OFS_IRQ_STAT   4'h4
`define EMCS_OFS_IRQ_MASK   4'h5
`define EMCS_OFS_MARGIN     4'h6
`define EMCS_OFS_PROT       4'h7
// status bit positions
`define EMCS_ST_CCF         7
`define EMCS_ST_ACC         5
`define EMCS_ST_PROT        4
`define EMCS_ST_VER         1
`define EMCS_ST_UNC         0
// irq status bit positions
`define EMCS_IRQ_DONE       0
`define EMCS_IRQ_ERR        1
// config bit positions
`define EMCS_CFG_SPECIAL    0
`define EMCS_CFG_SECURE     1
// command codes
`define EMCS_CMD_FMARGIN    8'h0E
`define EMCS_CMD_EVSECT     8'h10
`define EMCS_CMD_PROG       8'h11
`define EMCS_CMD_ERASE      8'h12
// parameter indices
`define EMCS_IX_001         3'h1
`define EMCS_IX_010         3'h2
`define EMCS_IX_101         3'h5
// margin encodings
`define EMCS_MRG_MAX        16'h0004
// block selection codes
`define EMCS_BLK_PFLASH     2'h0
`define EMCS_BLK_EEPROM     2'h1
// eeprom address window, 18-bit global addresses
`define EMCS_EE_HI          2'h0
`define EMCS_EE_BASE        16'h0400
`define EMCS_EE_END         16'h13FF
`define EMCS_SECT_MASK      16'hFFFC
// verify time per word in cycles
`define EMCS_WORD_CYC       4'h4
`endif

//--- test/emcs_seq_chk.sv
// port checker for the margin command sequencer
`timescale 1ns/10ps
`default_nettype none
`include "emcs_defines.vh"
module emcs_seq_chk
(
  input wire        clk_i,
  input wire        rst_n_i,
  input wire [3:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        irq_o,
  input wire [2:0]  pflash_margin_o,
  input wire [2:0]  eeprom_margin_o,
  input wire        arr_req_o,
  input wire [1:0]  arr_op_o,
  input wire [15:0] arr_addr_o,
  input wire [15:0] arr_data_o,
  input wire        arr_ack_i,
  input wire        arr_blank_fail_i,
  input wire        arr_err_i,
  input wire        arr_unc_i
);
  wire      go_w = avs_write_i && avs_waitrequest_o && avs_writedata_i[`EMCS_ST_CCF]
                   && (avs_address_i == `EMCS_OFS_STATUS);
  reg [3:0] go_q;
  // recent launch history
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      go_q <= 4'h0;
    else
      go_q <= {go_q[2:0], go_w};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("access not answered");
  a_unmapped_zero: assert property (avs_read_i && avs_waitrequest_o && avs_address_i[3]
    |=> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_irq_mask_off: assert property (avs_write_i && avs_waitrequest_o && avs_writedata_i[1:0] == 2'h0
    && avs_address_i == `EMCS_OFS_IRQ_MASK |-> ##[1:3] !irq_o)
    else $error("irq high with mask clear");
  a_arr_req_hold: assert property (arr_req_o && !arr_ack_i |=> arr_req_o && $stable(arr_addr_o)
    && $stable(arr_op_o) && $stable(arr_data_o))
    else $error("array request dropped or changed");
  a_req_after_ack: assert property ($rose(arr_req_o) |-> !arr_ack_i)
    else $error("array request raised during ack");
  a_addr_in_window: assert property (arr_req_o |-> !arr_addr_o[0] && arr_addr_o >= `EMCS_EE_BASE
    && arr_addr_o <= `EMCS_EE_END)
    else $error("array address odd or outside block");
  a_margin_range: assert property (pflash_margin_o <= 3'h4 && eeprom_margin_o <= 3'h4)
    else $error("margin level out of range");
  a_margin_cause: assert property ($changed(pflash_margin_o) || $changed(eeprom_margin_o)
    |-> go_q != 4'h0)
    else $error("margin changed without launch");
  c_launch: cover property (go_w);
  c_array: cover property ($rose(arr_req_o));
  c_irq: cover property ($rose(irq_o));
endmodule // emcs_seq_chk
bind emcs_sequencer emcs_seq_chk emcs_seq_chk_i
(.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
 .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
 .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .pflash_margin_o(pflash_margin_o),
 .eeprom_margin_o(eeprom_margin_o), .arr_req_o(arr_req_o), .arr_op_o(arr_op_o),
 .arr_addr_o(arr_addr_o), .arr_data_o(arr_data_o), .arr_ack_i(arr_ack_i),
 .arr_blank_fail_i(arr_blank_fail_i), .arr_err_i(arr_err_i), .arr_unc_i(arr_unc_i));
`default_nettype wire

//--- test/emcs_sequencer_bench.sv
// self-checking bench for the margin command sequencer
`timescale 1ns/10ps
`default_nettype none
`include "emcs_defines.vh"
module emcs_sequencer_bench;
  reg         clk_i, rst_n_i, rd_q, wr_q, ack_q, fail_q, err_q, unc_q;
  reg  [3:0]  adr_q;
  reg  [31:0] wd_q, rv;
  reg  [15:0] last_a, last_d;
  reg  [1:0]  last_op;
  wire [31:0] rdat;
  wire        wait_w, irq_w, req_w;
  wire [2:0]  pm_w, em_w;
  wire [1:0]  op_w;
  wire [15:0] aa_w, ad_w;
  integer     error_cnt, check_count, n_rd, n_wr, i;
  emcs_sequencer emcs_sequencer_i
  (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr_q), .avs_read_i(rd_q),
   .avs_write_i(wr_q), .avs_writedata_i(wd_q), .avs_readdata_o(rdat),
   .avs_waitrequest_o(wait_w), .irq_o(irq_w), .pflash_margin_o(pm_w),
   .eeprom_margin_o(em_w), .arr_req_o(req_w), .arr_op_o(op_w), .arr_addr_o(aa_w),
   .arr_data_o(ad_w), .arr_ack_i(ack_q), .arr_blank_fail_i(fail_q), .arr_err_i(err_q),
   .arr_unc_i(unc_q));
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // array responder and transfer log
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    ack_q <= req_w;
    if (req_w && !ack_q && op_w == 2'h0)
      n_rd = n_rd + 1;
    if (req_w && !ack_q && op_w != 2'h0)
    begin
      n_wr = n_wr + 1;
      last_a = aa_w;
      last_d = ad_w;
      last_op = op_w;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    integer n;
    begin
      adr_q <= a;
      wd_q <= d;
      wr_q <= w;
      rd_q <= !w;
      for (n = 0; n < 50 && wait_w !== 1'b0; n = n + 1)
        @(posedge clk_i);
      if (wait_w !== 1'b0)
        chk(32'h0, 32'h1);
      if (wait_w !== 1'b0)
        stop_test;
      rv = rdat;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  // load six words, set index, launch, wait, compare status flags
  task cmd(input [7:0] c, input [1:0] h, input [15:0] a, input [15:0] w2,
           input [2:0] ix, input [7:0] e);
    integer n;
    begin
      for (n = 0; n < 6; n = n + 1)
      begin
        bus(1'b1, `EMCS_OFS_INDEX, n);
        bus(1'b1, `EMCS_OFS_PARAM, n == 0 ? {c, 6'h0, h} : n == 1 ? a : n == 2 ? w2 : 16'hC0 + n);
      end
      bus(1'b1, `EMCS_OFS_INDEX, ix);
      bus(1'b1, `EMCS_OFS_STATUS, 32'h30);
      n_rd = 0;
      n_wr = 0;
      bus(1'b1, `EMCS_OFS_STATUS, 32'h80);
      rv = 32'h0;
      for (n = 0; n < 300 && rv[7] !== 1'b1; n = n + 1)
        bus(1'b0, `EMCS_OFS_STATUS, 32'h0);
      if (rv[7] !== 1'b1)
        chk(32'h0, 32'h1);
      if (rv[7] !== 1'b1)
        stop_test;
      chk(rv & 32'hB3, e);
    end
  endtask
  initial
  begin
    error_cnt = 0;
    check_count = 0;
    n_rd = 0;
    n_wr = 0;
    rst_n_i <= 1'b0;
    {rd_q, wr_q, fail_q, err_q, unc_q} <= 5'h00;
    adr_q <= 4'h0;
    wd_q <= 32'h0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, `EMCS_OFS_STATUS, 32'h0);
    chk(rv & 32'hB3, 32'h80);
    bus(1'b0, `EMCS_OFS_PROT, 32'h0);
    chk(rv, 32'hFFFF);
    bus(1'b1, 4'h8, 32'h5A);
    bus(1'b0, 4'h8, 32'h0);
    chk(rv, 32'h0);
    $display("test reset done");
    bus(1'b1, `EMCS_OFS_CONFIG, 32'h0);
    cmd(8'h0E, 2'h1, 16'h3, 16'h0, 3'h1, 8'hA0);
    bus(1'b1, `EMCS_OFS_CONFIG, 32'h1);
    for (i = 0; i < 5; i = i + 1)
    begin
      cmd(8'h0E, 2'h1, i, 16'h0, 3'h1, 8'h80);
      chk(em_w, i);
    end
    cmd(8'h0E, 2'h0, 16'h2, 16'h0, 3'h1, 8'h80);
    chk(pm_w, 32'h2);
    cmd(8'h0E, 2'h1, 16'h4, 16'h0, 3'h1, 8'h80);
    chk(pm_w, 32'h2);
    bus(1'b0, `EMCS_OFS_MARGIN, 32'h0);
    chk(rv & 32'h77, 32'h24);
    cmd(8'h0E, 2'h1, 16'h5, 16'h0, 3'h1, 8'hA0);
    cmd(8'h0E, 2'h2, 16'h1, 16'h0, 3'h1, 8'hA0);
    cmd(8'h0E, 2'h1, 16'h1, 16'h0, 3'h2, 8'hA0);
    chk(em_w, 32'h4);
    cmd(8'h0E, 2'h0, 16'h0, 16'h0, 3'h1, 8'h80);
    chk({pm_w, em_w}, 32'h0);
    bus(1'b1, `EMCS_OFS_CONFIG, 32'h3);
    cmd(8'h0E, 2'h1, 16'h1, 16'h0, 3'h1, 8'hA0);
    bus(1'b1, `EMCS_OFS_CONFIG, 32'h2);
    cmd(8'h11, 2'h0, 16'h0400, 16'h1234, 3'h2, 8'hA0);
    bus(1'b1, `EMCS_OFS_CONFIG, 32'h0);
    cmd(8'h20, 2'h0, 16'h0400, 16'h0, 3'h1, 8'hA0);
    $display("test margin done");
    cmd(8'h10, 2'h0, 16'h0400, 16'h4, 3'h2, 8'h80);
    chk(n_rd, 32'h4);
    fail_q <= 1'b1;
    cmd(8'h10, 2'h0, 16'h0400, 16'h4, 3'h2, 8'h83);
    fail_q <= 1'b0;
    err_q <= 1'b1;
    cmd(8'h10, 2'h0, 16'h0400, 16'h2, 3'h2, 8'h82);
    err_q <= 1'b0;
    cmd(8'h10, 2'h0, 16'h13FC, 16'h2, 3'h2, 8'h80);
    cmd(8'h10, 2'h0, 16'h13FC, 16'h3, 3'h2, 8'hA0);
    chk(n_rd + n_wr, 32'h0);
    cmd(8'h10, 2'h0, 16'h0401, 16'h2, 3'h2, 8'hA0);
    cmd(8'h10, 2'h0, 16'h0400, 16'h2, 3'h1, 8'hA0);
    cmd(8'h10, 2'h1, 16'h0400, 16'h2, 3'h2, 8'hA0);
    cmd(8'h10, 2'h0, 16'h0200, 16'h2, 3'h2, 8'hA0);
    $display("test verify done");
    for (i = 2; i < 6; i = i + 1)
    begin
      cmd(8'h12, 2'h0, 16'h0800, 16'h0, 3'h1, 8'h80);
      cmd(8'h12, 2'h0, 16'h0804, 16'h0, 3'h1, 8'h80);
      cmd(8'h11, 2'h0, 16'h0800, 16'hBEEF, i, 8'h80);
      chk(n_wr, i - 1);
    end
    chk({last_a, last_d}, 32'h080600C5);
    cmd(8'h11, 2'h0, 16'h0800, 16'hBEEF, 3'h1, 8'hA0);
    cmd(8'h11, 2'h0, 16'h0800, 16'hBEEF, 3'h6, 8'hA0);
    cmd(8'h11, 2'h0, 16'h13FE, 16'hBEEF, 3'h3, 8'hA0);
    cmd(8'h11, 2'h0, 16'h0803, 16'hBEEF, 3'h2, 8'hA0);
    bus(1'b1, `EMCS_OFS_PROT, 32'h1000);
    cmd(8'h11, 2'h0, 16'h0FFE, 16'hBEEF, 3'h3, 8'h90);
    cmd(8'h11, 2'h0, 16'h1000, 16'hBEEF, 3'h2, 8'h90);
    cmd(8'h12, 2'h0, 16'h1002, 16'h0, 3'h1, 8'h90);
    chk(n_rd + n_wr, 32'h0);
    err_q <= 1'b1;
    unc_q <= 1'b1;
    cmd(8'h12, 2'h0, 16'h0806, 16'h0, 3'h1, 8'h83);
    chk({last_op, last_a & 16'hFFFC}, 32'h20804);
    err_q <= 1'b0;
    unc_q <= 1'b0;
    cmd(8'h12, 2'h0, 16'h0806, 16'h0, 3'h2, 8'hA0);
    cmd(8'h12, 2'h0, 16'h0807, 16'h0, 3'h1, 8'hA0);
    cmd(8'h12, 2'h2, 16'h0804, 16'h0, 3'h1, 8'hA0);
    $display("test program erase done");
    bus(1'b1, `EMCS_OFS_IRQ_STAT, 32'h3);
    bus(1'b1, `EMCS_OFS_IRQ_MASK, 32'h1);
    cmd(8'h12, 2'h0, 16'h0400, 16'h0, 3'h1, 8'h80);
    chk(irq_w, 32'h1);
    bus(1'b1, `EMCS_OFS_IRQ_MASK, 32'h0);
    chk(irq_w, 32'h0);
    bus(1'b1, `EMCS_OFS_IRQ_MASK, 32'h1);
    bus(1'b0, `EMCS_OFS_IRQ_STAT, 32'h0);
    chk(rv & 32'h3, 32'h1);
    chk(irq_w, 32'h1);
    bus(1'b1, `EMCS_OFS_IRQ_STAT, 32'h1);
    bus(1'b0, `EMCS_OFS_IRQ_STAT, 32'h0);
    chk({rv[1:0], irq_w}, 32'h0);
    $display("test irq done");
    stop_test;
  end
endmodule // emcs_sequencer_bench
`default_nettype wire
